/* File: tb.sv */
// Self-checking testbench for the watchdog timer unit.
// Assumes the design package, header and module are compiled before this file.
`include "watchdog_timer_unit_regs.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import watchdog_timer_unit_pkg::*;

    // ****************************************
    // Signals and design
    // ****************************************
    localparam logic [15:0] PT = 16'h0003;
    logic       sys_clk_i;
    logic       nrst_i;
    logic       wdt_osc_i;
    logic       osc_run;
    logic [7:0] addr;
    logic       wr_s;
    logic       rd_s;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       rst_pin_i;
    logic       pin_o;
    logic       pin_oe_n;
    logic       wdt_rst;
    logic       p_high;
    logic       p0_hiz;
    int         fails;
    int         n_tests;
    logic [7:0] n;

    watchdog_timer_unit #(.PULSE_TICKS(PT)) u_dut
    (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .wdt_osc_i(wdt_osc_i), .osc_run_o(osc_run),
        .sfr_addr_i(addr), .sfr_wr_i(wr_s), .sfr_rd_i(rd_s), .sfr_wdata_i(wdata),
        .sfr_rdata_o(rdata), .rst_pin_i(rst_pin_i), .rst_pin_o(pin_o),
        .rst_pin_oe_n_o(pin_oe_n), .wdt_reset_o(wdt_rst), .port_high_o(p_high),
        .port0_hiz_o(p0_hiz)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(negedge sys_clk_i);
        wr_s = 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk_i);
        addr = a;
        rd_s = 1'b1;
        @(negedge sys_clk_i);
        rd_s = 1'b0;
        chk(rdata, e);
    endtask : rd_chk

    // k oscillator cycles, each with a settle cycle after it
    task automatic ticks(input int k);
        repeat (k)
        begin
            @(negedge sys_clk_i);
            wdt_osc_i = 1'b1;
            @(negedge sys_clk_i);
            wdt_osc_i = 1'b0;
            @(negedge sys_clk_i);
        end
    endtask : ticks

    function automatic logic [7:0] pins();
        return {2'h0, pin_o, wdt_rst, p_high, p0_hiz, osc_run, pin_oe_n};
    endfunction : pins

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // Clock, timeout and sequence
    // ****************************************
    initial
    begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    initial
    begin
        repeat (100000) @(posedge sys_clk_i);
        fails++;
        tally_and_finish();
    end

    initial
    begin
        fails = 0;
        n_tests = 0;
        nrst_i = 1'b0;
        wdt_osc_i = 1'b0;
        addr = 8'h00;
        wr_s = 1'b0;
        rd_s = 1'b0;
        wdata = 8'h00;
        rst_pin_i = 1'b0;
        repeat (12) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        chk(pins(), 8'h01);
        rd_chk(`WDT_CTRL_ADDR, 8'ha5);
        rd_chk(`WDT_COUNTER_ADDR, 8'h00);
        rd_chk(8'h00, `WDT_READ_UNMAPPED);
        wr(`WDT_COUNTER_ADDR, 8'h77);
        rd_chk(`WDT_COUNTER_ADDR, 8'h00);
        wr(`WDT_CTRL_ADDR, `WDT_CTRL_UNLOCK);
        wr(8'h00, 8'h33);
        rd_chk(`WDT_CTRL_ADDR, 8'h5a);
        chk({7'h0, osc_run}, 8'h01);
        wr(`WDT_COUNTER_ADDR, 8'hfe);
        rd_chk(`WDT_CTRL_ADDR, 8'h00);
        rd_chk(`WDT_COUNTER_ADDR, 8'hfe);
        wr(`WDT_COUNTER_ADDR, 8'h12);
        rd_chk(`WDT_COUNTER_ADDR, 8'hfe);
        ticks(2047);
        rd_chk(`WDT_COUNTER_ADDR, 8'hfe);
        ticks(1);
        rd_chk(`WDT_COUNTER_ADDR, 8'hff);
        ticks(2047);
        chk({7'h0, wdt_rst}, 8'h00);
        ticks(1);
        chk(pins(), 8'h3e);
        wr(`WDT_CTRL_ADDR, `WDT_CTRL_UNLOCK);
        n = 8'h00;
        for (int i = 0; i < 20 && wdt_rst === 1'b1; i++)
        begin
            ticks(1);
            n++;
        end
        chk(n, PT[7:0] + 8'h01);
        rd_chk(`WDT_CTRL_ADDR, 8'ha5);
        rd_chk(`WDT_COUNTER_ADDR, 8'h00);
        wr(`WDT_CTRL_ADDR, `WDT_CTRL_UNLOCK);
        wr(`WDT_COUNTER_ADDR, 8'h10);
        ticks(100);
        wr(`WDT_CTRL_ADDR, `WDT_CTRL_HALT);
        rd_chk(`WDT_COUNTER_ADDR, 8'h00);
        chk(pins(), 8'h01);
        wr(`WDT_CTRL_ADDR, 8'h33);
        ticks(2047);
        rd_chk(`WDT_COUNTER_ADDR, 8'h00);
        ticks(1);
        rd_chk(`WDT_COUNTER_ADDR, 8'h01);
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire

/* File: watchdog_timer_unit.sv */
// Watchdog timer: prescaler, counter, control register and reset pulse generator.
// Assumes the dedicated oscillator arrives as a slow level on wdt_osc_i, synchronous to sys_clk_i.
`include "watchdog_timer_unit_regs.svh"
`default_nettype none

module watchdog_timer_unit
#(
    parameter logic [`WDT_PULSE_W-1:0] PULSE_TICKS = 16'((`WDT_PULSE_MULT * `WDT_PULSE_BASE) - 1)
)
(
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    // Dedicated oscillator
    input  wire logic       wdt_osc_i,
    output logic            osc_run_o,
    // Register access
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    // Reset pin and chip reset
    input  wire logic       rst_pin_i,
    output logic            rst_pin_o,
    output logic            rst_pin_oe_n_o,
    output logic            wdt_reset_o,
    output logic            port_high_o,
    output logic            port0_hiz_o
);
    import watchdog_timer_unit_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    wdt_state_type                state_ff;
    wdt_state_type                nxt_state;
    logic [7:0]                   ctrl_ff;
    logic [`WDT_PRESC_W-1:0]      presc_ff;
    logic [7:0]                   cnt_ff;
    logic [`WDT_PULSE_W-1:0]      pulse_ff;
    logic                         osc_q_ff;
    logic [7:0]                   rdata_ff;
    logic                         tick;
    logic                         halted;
    logic                         in_reset;
    logic                         cnt_wr_ok;
    logic                         presc_wrap;
    logic                         overflow;

    // ****************************************
    // Oscillator sampling and decode
    // ****************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            osc_q_ff <= 1'b0;
        else
            osc_q_ff <= wdt_osc_i;
    end

    assign tick       = wdt_osc_i & ~osc_q_ff;
    assign in_reset   = (state_ff == ST_RESET);
    assign halted     = (ctrl_ff == `WDT_CTRL_HALT) & ~in_reset;
    assign cnt_wr_ok  = sfr_wr_i & (sfr_addr_i == `WDT_COUNTER_ADDR)
                        & (ctrl_ff == `WDT_CTRL_UNLOCK) & ~in_reset;
    assign presc_wrap = tick & (presc_ff == `WDT_PRESC_MAX);
    assign overflow   = (state_ff == ST_RUN) & ~halted & ~cnt_wr_ok & presc_wrap
                        & (cnt_ff == `WDT_COUNTER_MAX);
    assign osc_run_o  = ~halted;

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            ctrl_ff <= `WDT_CTRL_RESET;
        else if (in_reset)
            ctrl_ff <= `WDT_CTRL_RESET;
        else if (cnt_wr_ok)
            ctrl_ff <= `WDT_CTRL_CLEARED;
        else if (sfr_wr_i && sfr_addr_i == `WDT_CTRL_ADDR)
            ctrl_ff <= sfr_wdata_i;
    end

    // ****************************************
    // Prescaler and counter
    // ****************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            presc_ff <= '0;
        else if (halted || in_reset || cnt_wr_ok)
            presc_ff <= '0;
        else if (tick)
            presc_ff <= presc_ff + 1'b1;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            cnt_ff <= `WDT_COUNTER_RESET;
        else if (halted || in_reset)
            cnt_ff <= `WDT_COUNTER_RESET;
        else if (cnt_wr_ok)
            cnt_ff <= sfr_wdata_i;
        else if (presc_wrap)
            cnt_ff <= cnt_ff + 1'b1;
    end

    // ****************************************
    // Sequencer and reset pulse
    // ****************************************
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_OFF:
                if (ctrl_ff != `WDT_CTRL_HALT)
                    nxt_state = ST_RUN;
            ST_RUN:
                if (overflow)
                    nxt_state = ST_RESET;
                else if (halted)
                    nxt_state = ST_OFF;
            ST_RESET:
                if (tick && pulse_ff == PULSE_TICKS)
                    nxt_state = ST_OFF;
            default:
                nxt_state = ST_OFF;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            state_ff <= ST_OFF;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            pulse_ff <= '0;
        else if (!in_reset)
            pulse_ff <= '0;
        else if (tick)
            pulse_ff <= pulse_ff + 1'b1;
    end

    assign wdt_reset_o    = in_reset;
    assign rst_pin_o      = in_reset;
    assign rst_pin_oe_n_o = ~in_reset;
    assign port_high_o    = in_reset;
    assign port0_hiz_o    = in_reset;

    // ****************************************
    // Register read port
    // ****************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            rdata_ff <= `WDT_READ_UNMAPPED;
        else if (sfr_rd_i && sfr_addr_i == `WDT_COUNTER_ADDR)
            rdata_ff <= cnt_ff;
        else if (sfr_rd_i && sfr_addr_i == `WDT_CTRL_ADDR)
            rdata_ff <= ctrl_ff;
        else if (sfr_rd_i)
            rdata_ff <= `WDT_READ_UNMAPPED;
    end

    assign sfr_rdata_o = rdata_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    a_halt_clears: assert property ((ctrl_ff == `WDT_CTRL_HALT) && !cnt_wr_ok |=> presc_ff == '0 && cnt_ff == '0)
        else $error("halted watchdog did not hold counters at zero");
    a_write_locked: assert property (sfr_wr_i && sfr_addr_i == `WDT_COUNTER_ADDR && ctrl_ff != `WDT_CTRL_UNLOCK
        && ctrl_ff != `WDT_CTRL_HALT && !presc_wrap && !in_reset |=> cnt_ff == $past(cnt_ff))
        else $error("locked counter accepted a write");
    a_write_accept: assert property (cnt_wr_ok |=> cnt_ff == $past(sfr_wdata_i) && presc_ff == '0
        && ctrl_ff == `WDT_CTRL_CLEARED ##1 state_ff == ST_RUN)
        else $error("accepted counter write did not reload and relock");
    a_counter_step: assert property (presc_wrap && state_ff == ST_RUN && !halted && !cnt_wr_ok
        && cnt_ff != `WDT_COUNTER_MAX |=> cnt_ff == $past(cnt_ff) + 8'h01)
        else $error("counter missed a prescaler wrap");
    a_presc_step: assert property (tick && !halted && !in_reset && !cnt_wr_ok
        |=> presc_ff == $past(presc_ff) + 11'h001)
        else $error("prescaler missed an oscillator cycle");
    a_overflow_reset: assert property (overflow |=> wdt_reset_o && !rst_pin_oe_n_o && port_high_o && port0_hiz_o)
        else $error("overflow did not start the reset pulse");
    a_pin_ignored: assert property (overflow && !rst_pin_i |=> wdt_reset_o)
        else $error("low reset pin blocked the internal reset");
    a_reset_ctrl: assert property (wdt_reset_o |=> ctrl_ff == `WDT_CTRL_RESET)
        else $error("control not reloaded during watchdog reset");
    a_enable_run: assert property (state_ff == ST_OFF && ctrl_ff != `WDT_CTRL_HALT |=> state_ff == ST_RUN)
        else $error("watchdog did not start on enable value");
    a_read_live: assert property (sfr_rd_i && sfr_addr_i == `WDT_COUNTER_ADDR |=> sfr_rdata_o == $past(cnt_ff))
        else $error("counter read returned a stale value");

    c_reload: cover property (cnt_wr_ok ##[1:1000] presc_wrap);
    c_overflow: cover property (overflow);
    c_pulse_end: cover property (wdt_reset_o ##1 !wdt_reset_o);
    c_pin_low: cover property (overflow && !rst_pin_i);

endmodule : watchdog_timer_unit

`default_nettype wire

/* File: watchdog_timer_unit_pkg.sv */
// Types shared by the watchdog timer unit.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package watchdog_timer_unit_pkg;

    // ****************************************
    // Watchdog sequencer states, Gray along off, run, reset
    // ****************************************
    typedef enum logic [1:0]
    {
        ST_OFF   = 2'b00,
        ST_RUN   = 2'b01,
        ST_RESET = 2'b11
    } wdt_state_type;

endpackage : watchdog_timer_unit_pkg

`default_nettype wire

/* File: watchdog_timer_unit_regs.svh */
// Register map, field values and timing counts of the watchdog timer unit.
// Assumes inclusion by bare name from the design file.
`ifndef WATCHDOG_TIMER_UNIT_REGS_SVH
`define WATCHDOG_TIMER_UNIT_REGS_SVH

// ****************************************
// Register addresses
// ****************************************
`define WDT_CTRL_ADDR      8'ha5
`define WDT_COUNTER_ADDR   8'hff

// ****************************************
// Register values
// ****************************************
`define WDT_CTRL_RESET     8'ha5
`define WDT_CTRL_HALT      8'ha5
`define WDT_CTRL_UNLOCK    8'h5a
`define WDT_CTRL_CLEARED   8'h00
`define WDT_COUNTER_RESET  8'h00
`define WDT_READ_UNMAPPED  8'h00

// ****************************************
// Widths and timing counts
// ****************************************
`define WDT_PRESC_W        11
`define WDT_PRESC_MAX      11'h7ff
`define WDT_COUNTER_MAX    8'hff
`define WDT_PULSE_W        16
`define WDT_OSC_PERIOD_NS  1000
`define WDT_PULSE_MULT     16
`define WDT_PULSE_BASE     2048

`endif
